// ==== rtl/ea_calc.sv ====
`timescale 1ns/100ps
// Behaviour
// RULE1: instructions are whole 16-bit words.
// RULE2: function code is the top four bits; second field also decoded.
// RULE3: address register fields 3 bits; data register fields 3 or 4 bits.
// RULE4: extension is 8, 16 or 32 bits of immediate, address or displacement.
// RULE5: arithmetic uses register direct or immediate; transfers exclude pc-rel and indirect.
// RULE6: bit ops use direct, indirect or absolute; bit number register or 3-bit immediate.
// RULE7: register direct selects byte, word half or longword register.
// RULE8: indirect program address keeps low 24 bits, upper eight zero.
// RULE9: displacement added to register; 16-bit displacement sign-extended.
// RULE10: post-increment uses register address then address_add_small 1, 2 or 4.
// RULE11: pre-decrement subtracts 1, 2 or 4, uses and stores result.
// RULE12: software keeps register even for word and longword auto-steps.
// RULE13: abs8 upper ones, abs16 sign-extended, abs32 unmodified.
// RULE14: abs24 only for program addresses, upper eight zero; code also accepts abs24 for transfer and other classes.
// RULE15: small add/subtract imply immediate; trap carries 2-bit vector select.
// RULE16: pc-relative displacement sign-extended, added to next address, upper eight zero.
// RULE17: reach -126..+128 short, -32766..+32768 long from branch.
// RULE18: pc-relative only for branches; memory indirect only for jumps.
// RULE19: memory indirect pointer address zero-extended, 0 to 255.
// RULE20: pointer is word in normal, longword with zero first byte advanced.
// RULE21: odd word, longword or branch address has bit zero cleared.
// RULE22: normal mode discards upper bits, leaving 16-bit address.
// RULE23: static normal/advanced input, captured after reset, governs every calculation.
module ea_calc (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic advanced_i,
  input wire logic start_i,
  input wire logic [15:0] instr_word_i,
  input wire logic [3:0] second_code_i,
  input wire logic [3:0] mode_i,
  input wire logic [2:0] class_i,
  input wire logic [1:0] size_i,
  input wire logic [31:0] ext_i,
  input wire logic [31:0] reg_value_i,
  input wire logic [31:0] next_pc_i,
  input wire logic ptr_valid_i,
  input wire logic [31:0] ptr_data_i,
  output logic [3:0] function_code_o,
  output logic [3:0] second_code_o,
  output logic [2:0] addr_reg_o,
  output logic [3:0] data_reg_o,
  output logic [2:0] bit_num_o,
  output logic [1:0] trap_vector_o,
  output logic ptr_req_o,
  output logic [31:0] ptr_addr_o,
  output logic ptr_long_o,
  output logic [31:0] ea_o,
  output logic [31:0] reg_wb_o,
  output logic reg_wb_en_o,
  output logic is_prog_o,
  output logic ea_valid_o,
  output logic mode_illegal_o
);
  ////////////////////////////////////////////////////////////////////////
  ea_calc_pkg::seq_state_t state;
  ea_calc_pkg::ea_mode_t mode_q;
  ea_calc_pkg::instr_class_t class_q;
  ea_calc_pkg::access_size_t size_q;
  logic adv_q;
  logic adv_taken;
  logic [15:0] instr_q;
  logic [31:0] ext_q;
  logic [31:0] reg_q;
  logic [31:0] pc_q;
  logic [31:0] step;
  logic [31:0] raw_ea;
  logic [31:0] raw_wb;
  logic prog_addr;
  logic need_even;
  logic legal;
  logic [31:0] shaped_ea;
  logic [31:0] shaped_wb;
  logic [31:0] shaped_ptr;
  logic [31:0] ptr_target;

  ////////////////////////////////////////////////////////////////////////
  // mode strap taken on the first clock after reset, then frozen
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      adv_q <= 1'b0;
      adv_taken <= 1'b0;
    end else if (!adv_taken) begin
      adv_q <= advanced_i; // RULE23
      adv_taken <= 1'b1;
    end
  end

  // operands except second_code_i latched at start so later input changes do not disturb a calculation
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= ea_calc_pkg::mode_reg_direct;
      class_q <= ea_calc_pkg::cls_other;
      size_q <= ea_calc_pkg::size_byte;
      instr_q <= 16'h0000;
      ext_q <= ea_calc_pkg::reset_addr;
      reg_q <= ea_calc_pkg::reset_addr;
      pc_q <= ea_calc_pkg::reset_addr;
    end else if (start_i && state == ea_calc_pkg::st_idle) begin
      mode_q <= ea_calc_pkg::ea_mode_t'(mode_i);
      class_q <= ea_calc_pkg::instr_class_t'(class_i);
      size_q <= ea_calc_pkg::access_size_t'(size_i);
      instr_q <= instr_word_i; // RULE1
      ext_q <= ext_i; // RULE4
      reg_q <= reg_value_i;
      pc_q <= next_pc_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field decode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      function_code_o <= 4'h0;
      second_code_o <= 4'h0;
      addr_reg_o <= 3'h0;
      data_reg_o <= 4'h0;
      bit_num_o <= 3'h0;
      trap_vector_o <= 2'h0;
    end else if (state == ea_calc_pkg::st_calc) begin
      function_code_o <= instr_q[ea_calc_pkg::func_code_msb:ea_calc_pkg::func_code_lsb]; // RULE2
      second_code_o <= second_code_i; // RULE2
      addr_reg_o <= instr_q[ea_calc_pkg::addr_reg_lsb +: ea_calc_pkg::addr_reg_bits]; // RULE3
      data_reg_o <= instr_q[ea_calc_pkg::data_reg_lsb +: ea_calc_pkg::data_reg_bits]; // RULE7
      bit_num_o <= instr_q[ea_calc_pkg::bit_num_lsb +: ea_calc_pkg::bit_num_bits]; // RULE6
      trap_vector_o <= instr_q[ea_calc_pkg::trap_imm_lsb +: ea_calc_pkg::trap_imm_bits]; // RULE15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // legality of mode against instruction class
  always_comb begin
    case (class_q)
      ea_calc_pkg::cls_arith: legal = (mode_q == ea_calc_pkg::mode_reg_direct) ||
                                      (mode_q == ea_calc_pkg::mode_imm); // RULE5
      ea_calc_pkg::cls_transfer: legal = (mode_q != ea_calc_pkg::mode_pc_rel8) &&
                                         (mode_q != ea_calc_pkg::mode_pc_rel16) &&
                                         (mode_q != ea_calc_pkg::mode_mem_indirect); // RULE5
      ea_calc_pkg::cls_bit: legal = (mode_q == ea_calc_pkg::mode_reg_direct) ||
                                    (mode_q == ea_calc_pkg::mode_reg_indirect) ||
                                    (mode_q == ea_calc_pkg::mode_abs8) ||
                                    (mode_q == ea_calc_pkg::mode_abs16) ||
                                    (mode_q == ea_calc_pkg::mode_abs32); // RULE6
      ea_calc_pkg::cls_branch: legal = (mode_q == ea_calc_pkg::mode_pc_rel8) ||
                                       (mode_q == ea_calc_pkg::mode_pc_rel16); // RULE18
      ea_calc_pkg::cls_jump: legal = (mode_q == ea_calc_pkg::mode_mem_indirect) ||
                                     (mode_q == ea_calc_pkg::mode_reg_indirect) ||
                                     (mode_q == ea_calc_pkg::mode_abs24); // RULE18
      default: legal = (mode_q != ea_calc_pkg::mode_pc_rel8) &&
                       (mode_q != ea_calc_pkg::mode_pc_rel16) &&
                       (mode_q != ea_calc_pkg::mode_mem_indirect); // RULE18
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // raw address arithmetic
  always_comb begin
    case (size_q)
      ea_calc_pkg::size_word: step = ea_calc_pkg::step_word;
      ea_calc_pkg::size_long: step = ea_calc_pkg::step_long;
      default: step = ea_calc_pkg::step_byte;
    endcase
  end

  always_comb begin
    raw_ea = reg_q;
    raw_wb = reg_q;
    prog_addr = (class_q == ea_calc_pkg::cls_branch) || (class_q == ea_calc_pkg::cls_jump);
    case (mode_q)
      ea_calc_pkg::mode_reg_indirect: raw_ea = reg_q; // RULE8
      ea_calc_pkg::mode_disp16: raw_ea = reg_q + {{16{ext_q[15]}}, ext_q[15:0]}; // RULE9
      ea_calc_pkg::mode_disp32: raw_ea = reg_q + ext_q; // RULE9
      ea_calc_pkg::mode_post_inc: raw_wb = reg_q + step; // RULE10
      ea_calc_pkg::mode_pre_dec: begin
        raw_ea = reg_q - step; // RULE11
        raw_wb = reg_q - step; // RULE11
      end
      ea_calc_pkg::mode_abs8: raw_ea = {ea_calc_pkg::abs8_upper, {8{1'b1}}, ext_q[7:0]}; // RULE13
      ea_calc_pkg::mode_abs16: raw_ea = {{16{ext_q[15]}}, ext_q[15:0]}; // RULE13
      ea_calc_pkg::mode_abs24: begin
        raw_ea = {ea_calc_pkg::prog_upper, ext_q[23:0]}; // RULE14
        prog_addr = 1'b1; // RULE14
      end
      ea_calc_pkg::mode_abs32: raw_ea = ext_q; // RULE13
      ea_calc_pkg::mode_imm: raw_ea = ext_q; // RULE4
      // next_pc already points past the branch, giving -126..+128 for short
      ea_calc_pkg::mode_pc_rel8: raw_ea = pc_q + {{24{ext_q[7]}}, ext_q[7:0]}; // RULE16 RULE17
      ea_calc_pkg::mode_pc_rel16: raw_ea = pc_q + {{16{ext_q[15]}}, ext_q[15:0]}; // RULE16 RULE17
      ea_calc_pkg::mode_mem_indirect: raw_ea = {24'h000000, ext_q[7:0]}; // RULE19
      default: raw_ea = reg_q;
    endcase
  end

  // byte data accesses and immediates keep bit zero; program addresses, the pointer table address included, are evened
  assign need_even = prog_addr || (size_q != ea_calc_pkg::size_byte);

  ea_truncate u_trunc_ea (
    .addr_i(raw_ea),
    .prog_i(prog_addr),
    .even_i(need_even && mode_q != ea_calc_pkg::mode_imm),
    .advanced_i(adv_q),
    .addr_o(shaped_ea)
  );

  // the register itself is written back untouched by the evening logic
  assign shaped_wb = raw_wb;

  // fetched pointer: word in normal, longword with zero top byte in advanced
  always_comb begin
    if (adv_q) begin
      ptr_target = {ea_calc_pkg::prog_upper, ptr_data_i[23:0]}; // RULE20
    end else begin
      ptr_target = {16'h0000, ptr_data_i[15:0]}; // RULE20
    end
  end

  ea_truncate u_trunc_ptr (
    .addr_i(ptr_target),
    .prog_i(1'b1),
    .even_i(1'b1),
    .advanced_i(adv_q),
    .addr_o(shaped_ptr)
  );

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ea_calc_pkg::st_idle;
    end else begin
      case (state)
        ea_calc_pkg::st_idle: if (start_i) state <= ea_calc_pkg::st_calc;
        ea_calc_pkg::st_calc: begin
          if (legal && mode_q == ea_calc_pkg::mode_mem_indirect) begin
            state <= ea_calc_pkg::st_ptr_wait;
          end else begin
            state <= ea_calc_pkg::st_done;
          end
        end
        ea_calc_pkg::st_ptr_wait: if (ptr_valid_i) state <= ea_calc_pkg::st_done;
        ea_calc_pkg::st_done: state <= ea_calc_pkg::st_idle;
        default: state <= ea_calc_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ea_o <= ea_calc_pkg::reset_addr;
      reg_wb_o <= ea_calc_pkg::reset_addr;
      reg_wb_en_o <= 1'b0;
      is_prog_o <= 1'b0;
      ea_valid_o <= 1'b0;
      mode_illegal_o <= 1'b0;
      ptr_req_o <= 1'b0;
      ptr_addr_o <= ea_calc_pkg::reset_addr;
      ptr_long_o <= 1'b0;
    end else begin
      ea_valid_o <= 1'b0;
      reg_wb_en_o <= 1'b0;
      case (state)
        ea_calc_pkg::st_calc: begin
          mode_illegal_o <= !legal;
          is_prog_o <= prog_addr;
          if (legal && mode_q == ea_calc_pkg::mode_mem_indirect) begin
            ptr_req_o <= 1'b1;
            ptr_addr_o <= shaped_ea; // RULE19
            ptr_long_o <= adv_q; // RULE20
          end else begin
            ea_o <= shaped_ea; // RULE22
            ea_valid_o <= 1'b1;
            reg_wb_o <= shaped_wb;
            reg_wb_en_o <= legal && (mode_q == ea_calc_pkg::mode_post_inc ||
                                     mode_q == ea_calc_pkg::mode_pre_dec); // RULE10 RULE11
          end
        end
        ea_calc_pkg::st_ptr_wait: begin
          if (ptr_valid_i) begin
            ptr_req_o <= 1'b0;
            ea_o <= shaped_ptr; // RULE21
            ea_valid_o <= 1'b1;
          end
        end
        default: ptr_req_o <= ptr_req_o;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_normal_trunc;
    @(posedge clk_i) disable iff (rst_i)
      ea_valid_o && !adv_q |-> ea_o[31:16] == 16'h0000;
  endproperty
  a_normal_trunc: assert property (p_normal_trunc) else $error("normal ea above 16 bits"); // RULE22

  property p_prog_upper;
    @(posedge clk_i) disable iff (rst_i)
      ea_valid_o && is_prog_o |-> ea_o[31:24] == 8'h00 && ea_o[0] == 1'b0;
  endproperty
  a_prog_upper: assert property (p_prog_upper) else $error("program address not shaped"); // RULE8

  property p_post_inc;
    @(posedge clk_i) disable iff (rst_i)
      state == ea_calc_pkg::st_calc && legal && mode_q == ea_calc_pkg::mode_post_inc
      |=> reg_wb_en_o && reg_wb_o == $past(reg_q) + $past(step);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post-increment write-back wrong"); // RULE10

  property p_pre_dec;
    @(posedge clk_i) disable iff (rst_i)
      state == ea_calc_pkg::st_calc && legal && mode_q == ea_calc_pkg::mode_pre_dec
      |=> reg_wb_en_o && reg_wb_o == $past(reg_q) - $past(step);
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("pre-decrement write-back wrong"); // RULE11

  property p_abs8;
    @(posedge clk_i) disable iff (rst_i)
      state == ea_calc_pkg::st_calc && mode_q == ea_calc_pkg::mode_abs8 && adv_q
      |=> ea_o[31:8] == 24'hffffff;
  endproperty
  a_abs8: assert property (p_abs8) else $error("abs8 upper bits not ones"); // RULE13

  property p_arith_legal;
    @(posedge clk_i) disable iff (rst_i)
      state == ea_calc_pkg::st_calc && class_q == ea_calc_pkg::cls_arith &&
      mode_q == ea_calc_pkg::mode_abs16 |=> mode_illegal_o;
  endproperty
  a_arith_legal: assert property (p_arith_legal) else $error("arith mode not refused"); // RULE5

  property p_ptr_range;
    @(posedge clk_i) disable iff (rst_i)
      $rose(ptr_req_o) |-> ptr_addr_o[31:8] == 24'h000000;
  endproperty
  a_ptr_range: assert property (p_ptr_range) else $error("pointer address above 255"); // RULE19

  property p_ptr_done;
    @(posedge clk_i) disable iff (rst_i)
      ptr_req_o && ptr_valid_i |=> ea_valid_o && !ptr_req_o && ea_o[0] == 1'b0;
  endproperty
  a_ptr_done: assert property (p_ptr_done) else $error("pointer target not delivered"); // RULE20

  property p_mode_frozen;
    @(posedge clk_i) disable iff (rst_i)
      adv_taken |=> $stable(adv_q);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("address mode changed"); // RULE23
endmodule : ea_calc

// ==== inc/ea_calc_pkg.sv ====
package ea_calc_pkg;
  // addressing modes
  typedef enum logic [3:0] {
    mode_reg_direct = 4'h0,
    mode_reg_indirect = 4'h1,
    mode_disp16 = 4'h2,
    mode_disp32 = 4'h3,
    mode_post_inc = 4'h4,
    mode_pre_dec = 4'h5,
    mode_abs8 = 4'h6,
    mode_abs16 = 4'h7,
    mode_abs24 = 4'h8,
    mode_abs32 = 4'h9,
    mode_imm = 4'ha,
    mode_pc_rel8 = 4'hb,
    mode_pc_rel16 = 4'hc,
    mode_mem_indirect = 4'hd
  } ea_mode_t;

  // instruction classes
  typedef enum logic [2:0] {
    cls_arith = 3'h0,
    cls_transfer = 3'h1,
    cls_bit = 3'h2,
    cls_branch = 3'h3,
    cls_jump = 3'h4,
    cls_other = 3'h5
  } instr_class_t;

  // access size
  typedef enum logic [1:0] {
    size_byte = 2'h0,
    size_word = 2'h1,
    size_long = 2'h2
  } access_size_t;

  // sequencer states, one bit changing from idle to calc to done
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_calc = 2'b01,
    st_ptr_wait = 2'b10,
    st_done = 2'b11
  } seq_state_t;

  localparam int unsigned word_bits = 16;
  localparam int unsigned addr_bits = 32;
  localparam int unsigned func_code_msb = 15;
  localparam int unsigned func_code_lsb = 12;
  localparam int unsigned addr_reg_bits = 3;
  localparam int unsigned data_reg_bits = 4;
  localparam int unsigned bit_num_bits = 3;
  localparam int unsigned trap_imm_bits = 2;
  localparam int unsigned addr_reg_lsb = 4;
  localparam int unsigned data_reg_lsb = 0;
  localparam int unsigned bit_num_lsb = 4;
  localparam int unsigned trap_imm_lsb = 4;
  localparam logic [31:0] step_byte = 32'h0000_0001;
  localparam logic [31:0] step_word = 32'h0000_0002;
  localparam logic [31:0] step_long = 32'h0000_0004;
  localparam logic [15:0] abs8_upper = 16'hffff;
  localparam logic [7:0] prog_upper = 8'h00;
  localparam logic [31:0] prog_mask = 32'h00ff_ffff;
  localparam logic [31:0] normal_mask = 32'h0000_ffff;
  localparam logic [31:0] even_mask = 32'hffff_fffe;
  localparam logic [31:0] reset_addr = 32'h0000_0000;
endpackage : ea_calc_pkg

// ==== rtl/ea_truncate.sv ====
`timescale 1ns/100ps
// final address shaping shared by the operand and fetched-pointer paths
module ea_truncate (
  input wire logic [31:0] addr_i,
  input wire logic prog_i,
  input wire logic even_i,
  input wire logic advanced_i,
  output logic [31:0] addr_o
);
  logic [31:0] t0;
  logic [31:0] t1;
  always_comb begin
    t0 = prog_i ? (addr_i & ea_calc_pkg::prog_mask) : addr_i; // RULE8
    t1 = even_i ? (t0 & ea_calc_pkg::even_mask) : t0; // RULE21
    addr_o = advanced_i ? t1 : (t1 & ea_calc_pkg::normal_mask); // RULE22
  end
endmodule : ea_truncate

// ==== verif/test_ea_calc.sv ====
`timescale 1ns/100ps
module test_ea_calc;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic advanced_i = 1'b1;
  logic start_i = 1'b0;
  logic [15:0] instr_word_i = 16'h0000;
  logic [3:0] second_code_i = 4'h0;
  logic [3:0] mode_i = 4'h0;
  logic [2:0] class_i = 3'h0;
  logic [1:0] size_i = 2'h0;
  logic [31:0] ext_i = 32'h0000_0000;
  logic [31:0] reg_value_i = 32'h0000_0000;
  logic [31:0] next_pc_i = 32'h0000_0000;
  logic ptr_valid_i = 1'b0;
  logic [31:0] ptr_data_i = 32'h0000_0000;
  logic [3:0] function_code_o;
  logic [3:0] second_code_o;
  logic [2:0] addr_reg_o;
  logic [3:0] data_reg_o;
  logic [2:0] bit_num_o;
  logic [1:0] trap_vector_o;
  logic ptr_req_o;
  logic [31:0] ptr_addr_o;
  logic ptr_long_o;
  logic [31:0] ea_o;
  logic [31:0] reg_wb_o;
  logic reg_wb_en_o;
  logic is_prog_o;
  logic ea_valid_o;
  logic mode_illegal_o;
  int n_fail = 0;
  int n_tests = 0;

  always #5 clk_i = ~clk_i;

  ea_calc ea_calc_inst (
    .clk_i(clk_i), .rst_i(rst_i), .advanced_i(advanced_i), .start_i(start_i),
    .instr_word_i(instr_word_i), .second_code_i(second_code_i), .mode_i(mode_i),
    .class_i(class_i), .size_i(size_i), .ext_i(ext_i), .reg_value_i(reg_value_i),
    .next_pc_i(next_pc_i), .ptr_valid_i(ptr_valid_i), .ptr_data_i(ptr_data_i),
    .function_code_o(function_code_o), .second_code_o(second_code_o),
    .addr_reg_o(addr_reg_o), .data_reg_o(data_reg_o), .bit_num_o(bit_num_o),
    .trap_vector_o(trap_vector_o), .ptr_req_o(ptr_req_o), .ptr_addr_o(ptr_addr_o),
    .ptr_long_o(ptr_long_o), .ea_o(ea_o), .reg_wb_o(reg_wb_o),
    .reg_wb_en_o(reg_wb_en_o), .is_prog_o(is_prog_o), .ea_valid_o(ea_valid_o),
    .mode_illegal_o(mode_illegal_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: flag got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag

  // strap is only read right after release, so a mode change needs a full reset
  task automatic do_reset(input logic adv);
    rst_i = 1'b1;
    advanced_i = adv;
    repeat (6) @(posedge clk_i);
    #1;
    chk(ea_o, 32'h0000_0000);
    chk_flag(ea_valid_o, 1'b0);
    rst_i = 1'b0;
    @(posedge clk_i);
    #1;
  endtask : do_reset

  task automatic wait_valid;
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      #1;
      ptr_valid_i = 1'b0;
      if (ea_valid_o === 1'b1) begin
        return;
      end
    end
    n_fail++;
    $display("Error at %0t: no completion got %h expected %h", $time, ea_valid_o, 1'b1);
    complete_run();
  endtask : wait_valid

  task automatic op(input logic [3:0] m, input logic [2:0] c, input logic [1:0] s,
                    input logic [31:0] ext, input logic [31:0] rv, input logic [31:0] pc);
    @(posedge clk_i);
    #1;
    mode_i = m;
    class_i = c;
    size_i = s;
    ext_i = ext;
    reg_value_i = rv;
    next_pc_i = pc;
    start_i = 1'b1;
    @(posedge clk_i);
    #1;
    start_i = 1'b0;
    wait_valid();
  endtask : op

  // plain address check: value and legal flag, write-back not examined
  task automatic ea_case(input logic [3:0] m, input logic [2:0] c, input logic [1:0] s,
                         input logic [31:0] ext, input logic [31:0] rv, input logic [31:0] pc,
                         input logic [31:0] exp);
    op(m, c, s, ext, rv, pc);
    chk(ea_o, exp);
    chk_flag(mode_illegal_o, 1'b0);
  endtask : ea_case

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_fields;
    instr_word_i = 16'ha5b7;
    second_code_i = 4'hc;
    op(ea_calc_pkg::mode_reg_direct, ea_calc_pkg::cls_arith, ea_calc_pkg::size_byte,
       32'h0, 32'h0, 32'h0);
    chk({28'h0, function_code_o}, 32'h0000_000a);
    chk({28'h0, second_code_o}, 32'h0000_000c);
    chk({29'h0, addr_reg_o}, 32'h0000_0003);
    chk({28'h0, data_reg_o}, 32'h0000_0007);
    chk({29'h0, bit_num_o}, 32'h0000_0003);
    chk({30'h0, trap_vector_o}, 32'h0000_0003);
    @(posedge clk_i);
    #1;
    chk_flag(ea_valid_o, 1'b0);
    $display("test fields done");
  endtask : test_fields

  task automatic test_disp;
    ea_case(ea_calc_pkg::mode_disp16, ea_calc_pkg::cls_transfer, ea_calc_pkg::size_byte,
            32'h0000_fffc, 32'h0010_0000, 32'h0, 32'h000f_fffc);
    ea_case(ea_calc_pkg::mode_disp32, ea_calc_pkg::cls_transfer, ea_calc_pkg::size_word,
            32'h0001_0000, 32'h0011_0001, 32'h0, 32'h0012_0000);
    chk_flag(is_prog_o, 1'b0);
    $display("test disp done");
  endtask : test_disp

  task automatic test_steps;
    logic [31:0] st [3];
    int k;
    st = '{32'h1, 32'h2, 32'h4};
    for (k = 0; k < 3; k++) begin
      op(ea_calc_pkg::mode_post_inc, ea_calc_pkg::cls_transfer, 2'(k),
         32'h0, 32'h0000_1000, 32'h0);
      chk(ea_o, 32'h0000_1000);
      chk(reg_wb_o, 32'h0000_1000 + st[k]);
      chk_flag(reg_wb_en_o, 1'b1);
      op(ea_calc_pkg::mode_pre_dec, ea_calc_pkg::cls_transfer, 2'(k),
         32'h0, 32'h0000_2000, 32'h0);
      chk(ea_o, 32'h0000_2000 - st[k]);
      chk(reg_wb_o, 32'h0000_2000 - st[k]);
      chk_flag(reg_wb_en_o, 1'b1);
    end
    $display("test steps done");
  endtask : test_steps

  task automatic test_abs;
    ea_case(ea_calc_pkg::mode_abs8, ea_calc_pkg::cls_transfer, ea_calc_pkg::size_byte,
            32'h0000_0012, 32'h0, 32'h0, 32'hffff_ff12);
    ea_case(ea_calc_pkg::mode_abs16, ea_calc_pkg::cls_transfer, ea_calc_pkg::size_byte,
            32'h0000_8001, 32'h0, 32'h0, 32'hffff_8001);
    ea_case(ea_calc_pkg::mode_abs32, ea_calc_pkg::cls_transfer, ea_calc_pkg::size_byte,
            32'h1234_5679, 32'h0, 32'h0, 32'h1234_5679);
    ea_case(ea_calc_pkg::mode_abs16, ea_calc_pkg::cls_transfer, ea_calc_pkg::size_long,
            32'h0000_1235, 32'h0, 32'h0, 32'h0000_1234);
    ea_case(ea_calc_pkg::mode_abs24, ea_calc_pkg::cls_jump, ea_calc_pkg::size_byte,
            32'h8012_3457, 32'h0, 32'h0, 32'h0012_3456);
    chk_flag(is_prog_o, 1'b1);
    ea_case(ea_calc_pkg::mode_reg_indirect, ea_calc_pkg::cls_jump, ea_calc_pkg::size_byte,
            32'h0, 32'hff12_3455, 32'h0, 32'h0012_3454);
    $display("test abs done");
  endtask : test_abs

  task automatic test_pcrel;
    ea_case(ea_calc_pkg::mode_pc_rel8, ea_calc_pkg::cls_branch, ea_calc_pkg::size_byte,
            32'h0000_0080, 32'h0, 32'h0000_1002, 32'h0000_0f82);
    ea_case(ea_calc_pkg::mode_pc_rel8, ea_calc_pkg::cls_branch, ea_calc_pkg::size_byte,
            32'h0000_007e, 32'h0, 32'hab00_1002, 32'h0000_1080);
    ea_case(ea_calc_pkg::mode_pc_rel16, ea_calc_pkg::cls_branch, ea_calc_pkg::size_byte,
            32'h0000_8000, 32'h0, 32'h0001_0002, 32'h0000_8002);
    ea_case(ea_calc_pkg::mode_pc_rel16, ea_calc_pkg::cls_branch, ea_calc_pkg::size_byte,
            32'h0000_0011, 32'h0, 32'h0000_2000, 32'h0000_2010);
    $display("test pcrel done");
  endtask : test_pcrel

  // pointer fetch; width depends on the strap
  task automatic test_mem_ind(input logic adv, input logic [31:0] data,
                              input logic [31:0] exp);
    int i;
    @(posedge clk_i);
    #1;
    mode_i = ea_calc_pkg::mode_mem_indirect;
    class_i = ea_calc_pkg::cls_jump;
    ext_i = 32'hffff_ff84;
    start_i = 1'b1;
    @(posedge clk_i);
    #1;
    start_i = 1'b0;
    for (i = 0; i < 20 && ptr_req_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk_flag(ptr_req_o, 1'b1);
    chk(ptr_addr_o, 32'h0000_0084);
    chk_flag(ptr_long_o, adv);
    ptr_data_i = data;
    ptr_valid_i = 1'b1;
    wait_valid();
    chk(ea_o, exp);
    chk_flag(ptr_req_o, 1'b0);
    $display("test mem_ind done");
  endtask : test_mem_ind

  task automatic test_illegal;
    logic [3:0] m [4];
    logic [2:0] c [4];
    int k;
    m = '{ea_calc_pkg::mode_abs16, ea_calc_pkg::mode_pc_rel8,
          ea_calc_pkg::mode_disp16, ea_calc_pkg::mode_mem_indirect};
    c = '{ea_calc_pkg::cls_arith, ea_calc_pkg::cls_transfer,
          ea_calc_pkg::cls_bit, ea_calc_pkg::cls_branch};
    for (k = 0; k < 4; k++) begin
      op(m[k], c[k], ea_calc_pkg::size_byte, 32'h0, 32'h0000_1000, 32'h0);
      chk_flag(mode_illegal_o, 1'b1);
      chk_flag(reg_wb_en_o, 1'b0);
    end
    op(ea_calc_pkg::mode_post_inc, ea_calc_pkg::cls_arith, ea_calc_pkg::size_word,
       32'h0, 32'h0000_1000, 32'h0);
    chk_flag(reg_wb_en_o, 1'b0);
    $display("test illegal done");
  endtask : test_illegal

  task automatic test_normal;
    ea_case(ea_calc_pkg::mode_disp32, ea_calc_pkg::cls_transfer, ea_calc_pkg::size_byte,
            32'h0000_0000, 32'h0012_3457, 32'h0, 32'h0000_3457);
    ea_case(ea_calc_pkg::mode_abs8, ea_calc_pkg::cls_transfer, ea_calc_pkg::size_byte,
            32'h0000_0012, 32'h0, 32'h0, 32'h0000_ff12);
    $display("test normal done");
  endtask : test_normal

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b1);
    test_fields();
    test_disp();
    test_steps();
    test_abs();
    test_pcrel();
    test_mem_ind(1'b1, 32'hff00_2001, 32'h0000_2000);
    test_illegal();
    do_reset(1'b0);
    test_normal();
    test_mem_ind(1'b0, 32'h0000_abcd, 32'h0000_abcc);
    complete_run();
  end
endmodule : test_ea_calc
